// ### src/bds_map.vh
// Constants for the backoff diagnose self-test block
`ifndef BDS_MAP_VH
`define BDS_MAP_VH

// ----------------------------------------------------------------------
// Command block layout
// ----------------------------------------------------------------------
`define BDS_CB_WORD0_OFS    32'h0000_0000
`define BDS_CB_LINK_OFS     32'h0000_0004
`define BDS_BIT_EOL         31
`define BDS_BIT_SUSPEND     30
`define BDS_BIT_IRQ         29
`define BDS_CMD_HI          18
`define BDS_CMD_LO          16
`define BDS_CMD_DIAGNOSE    3'h7
`define BDS_BIT_COMPLETE    15
`define BDS_BIT_OK          13
`define BDS_BIT_FAIL        11

// ----------------------------------------------------------------------
// Command unit states
// ----------------------------------------------------------------------
`define BDS_CU_IDLE         2'h0
`define BDS_CU_ACTIVE       2'h1
`define BDS_CU_SUSPENDED    2'h2

// ----------------------------------------------------------------------
// Self-test constants
// ----------------------------------------------------------------------
`define BDS_LFSR_SEED       30'h0000_0001
`define BDS_LFSR_TAPS       30'h2000_0029
`define BDS_LOW10_ONES      10'h3FF
`define BDS_SLOT_PRE_STEP   11'h3FF
`define BDS_SLOT_POST_STEP  11'h400
`define BDS_P2_SLOT_PERIOD  4'h3
`define BDS_P2_LINEAR_PRIORITY_SETTING     4'h6
`define BDS_P2_EXPONENTIAL_PRIORITY_SETTING     4'h3
`define BDS_P2_BACKOFF_METHOD_SETTING      4'h0
`define BDS_COLL_LIMIT      4'hF

`endif

// ### src/bds_selftest.v
// Two-phase self-test of the collision backoff logic
`timescale 1ns/1ps
`include "bds_map.vh"

module bds_selftest (
  input  wire i_clk,
  input  wire i_rst_b,
  input  wire i_start,
  output reg  o_done,
  output reg  o_fail
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_P1_CLR = 3'h1;
  localparam [2:0] ST_P1_RUN = 3'h2;
  localparam [2:0] ST_P1_CHK = 3'h3;
  localparam [2:0] ST_P2_CLR = 3'h4;
  localparam [2:0] ST_P2_RUN = 3'h5;
  localparam [2:0] ST_P2_CHK = 3'h6;

  reg [2:0]  state;
  reg [29:0] lfsr;
  reg [9:0]  backoff;
  reg [10:0] slot;
  reg [3:0]  coll;
  reg [9:0]  shreg;
  reg        p1_err;
  reg [3:0]  slot_period;
  reg [3:0]  linear_priority_setting;
  reg [3:0]  exponential_priority_setting;
  reg [3:0]  backoff_method_setting;

  function [29:0] bds_lfsr_next;
    input [29:0] cur;
    begin
      bds_lfsr_next = {cur[28:0], ^(cur & `BDS_LFSR_TAPS)};
    end
  endfunction

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state       <= ST_IDLE;
      lfsr        <= `BDS_LFSR_SEED;
      backoff     <= 10'h000;
      slot        <= 11'h000;
      coll        <= 4'h0;
      shreg       <= 10'h000;
      p1_err      <= 1'b0;
      slot_period <= 4'h0;
      linear_priority_setting    <= 4'h0;
      exponential_priority_setting    <= 4'h0;
      backoff_method_setting     <= 4'h0;
      o_done      <= 1'b0;
      o_fail      <= 1'b0;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            state <= ST_P1_CLR;
          end
        end
        ST_P1_CLR: begin
          lfsr    <= `BDS_LFSR_SEED;
          backoff <= 10'h000;
          slot    <= 11'h000;
          coll    <= 4'h0;
          shreg   <= 10'h000;
          p1_err  <= 1'b0;
          state   <= ST_P1_RUN;
        end
        ST_P1_RUN: begin
          lfsr    <= bds_lfsr_next(lfsr);
          backoff <= backoff + 10'h001;
          slot    <= slot + 11'h001;
          coll    <= coll + 4'h1;
          shreg   <= {shreg[8:0], 1'b1};
          if (lfsr[9:0] == `BDS_LOW10_ONES && shreg != `BDS_LOW10_ONES) begin
            p1_err <= 1'b1;
          end
          if (backoff == `BDS_LOW10_ONES) begin
            if (slot != `BDS_SLOT_PRE_STEP || coll != 4'hF) begin
              p1_err <= 1'b1;
            end
            state <= ST_P1_CHK;
          end
        end
        ST_P1_CHK: begin
          if (backoff != 10'h000 || slot != `BDS_SLOT_POST_STEP || slot[9:0] != 10'h000 ||
              coll != 4'h0 || lfsr == 30'h0000_0000) begin
            p1_err <= 1'b1;
          end
          state <= ST_P2_CLR;
        end
        ST_P2_CLR: begin
          lfsr        <= `BDS_LFSR_SEED;
          backoff     <= {6'h00, `BDS_P2_LINEAR_PRIORITY_SETTING};
          slot        <= 11'h000;
          coll        <= 4'h0;
          shreg       <= 10'h000;
          slot_period <= `BDS_P2_SLOT_PERIOD;
          linear_priority_setting    <= `BDS_P2_LINEAR_PRIORITY_SETTING;
          exponential_priority_setting    <= `BDS_P2_EXPONENTIAL_PRIORITY_SETTING;
          backoff_method_setting     <= `BDS_P2_BACKOFF_METHOD_SETTING;
          state       <= ST_P2_RUN;
        end
        ST_P2_RUN: begin
          lfsr <= bds_lfsr_next(lfsr);
          if (slot[3:0] + 4'h1 < slot_period) begin
            slot <= slot + 11'h001;
          end else if (backoff != 10'h000) begin
            slot    <= 11'h000;
            backoff <= backoff - 10'h001;
          end else begin
            slot    <= 11'h000;
            coll    <= coll + 4'h1;
            backoff <= {6'h00, linear_priority_setting} + (lfsr[9:0] & shreg);
            if (backoff_method_setting == 4'h0 && coll >= exponential_priority_setting) begin
              shreg <= {shreg[8:0], 1'b1};
            end
            state <= ST_P2_CHK;
          end
        end
        ST_P2_CHK: begin
          if (shreg[9]) begin
            o_done <= 1'b1;
            o_fail <= p1_err;
            state  <= ST_IDLE;
          end else if (coll == `BDS_COLL_LIMIT) begin
            o_done <= 1'b1;
            o_fail <= 1'b1;
            state  <= ST_IDLE;
          end else begin
            state <= ST_P2_RUN;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // bds_selftest

// ### src/bds_top.v
// Diagnose action command: command block fetch, self-test, status write-back
`timescale 1ns/1ps
`include "bds_map.vh"

module bds_top (
  input  wire        I_CLK,
  input  wire        I_RST_B,
  input  wire        I_START,
  input  wire        I_RESUME,
  input  wire [31:0] I_CU_BASE,
  input  wire [31:0] I_CB_OFFSET,
  input  wire        I_CFG_SUSPEND_EVENT_EN,
  input  wire        I_MEM_ACK,
  input  wire [31:0] I_MEM_RDATA,
  output reg         O_MEM_REQ,
  output reg         O_MEM_WE,
  output reg  [31:0] O_MEM_ADDR,
  output reg  [31:0] O_MEM_WDATA,
  output reg  [1:0]  O_CU_STATE,
  output reg  [31:0] O_NEXT_ADDR,
  output reg         O_UNIT_IDLE_EVENT,
  output reg         O_UNIT_LEFT_ACTIVE_EVENT,
  output reg         O_COMMAND_DONE_EVENT,
  output reg         O_SELFTEST_FAIL
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] FS_IDLE   = 3'h0;
  localparam [2:0] FS_WORD0  = 3'h1;
  localparam [2:0] FS_LINK   = 3'h2;
  localparam [2:0] FS_TEST   = 3'h3;
  localparam [2:0] FS_WAIT   = 3'h4;
  localparam [2:0] FS_STATUS = 3'h5;
  localparam [2:0] FS_FINISH = 3'h6;

  reg  [2:0]  state;
  reg  [31:0] cb_addr;
  reg  [31:0] cmd_word;
  reg  [31:0] link;
  reg         test_start;
  reg         ok_flag;
  reg         fail_flag;
  wire        test_done;
  wire        test_fail;

  function [31:0] bds_add;
    input [31:0] a;
    input [31:0] b;
    begin
      bds_add = a + b;
    end
  endfunction

  function bds_is_diag;
    input [31:0] w;
    begin
      bds_is_diag = (w[`BDS_CMD_HI:`BDS_CMD_LO] == `BDS_CMD_DIAGNOSE);
    end
  endfunction

  // --------------------------------------------------------------------
  // Self-test engine
  // --------------------------------------------------------------------
  bds_selftest u_selftest (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_start (test_start),
    .o_done  (test_done),
    .o_fail  (test_fail)
  );

  // --------------------------------------------------------------------
  // Command unit sequencer
  // --------------------------------------------------------------------
  always @(posedge I_CLK) begin
    if (!I_RST_B) begin
      state                    <= FS_IDLE;
      cb_addr                  <= 32'h0000_0000;
      cmd_word                 <= 32'h0000_0000;
      link                     <= 32'h0000_0000;
      test_start               <= 1'b0;
      ok_flag                  <= 1'b0;
      fail_flag                <= 1'b0;
      O_MEM_REQ                <= 1'b0;
      O_MEM_WE                 <= 1'b0;
      O_MEM_ADDR               <= 32'h0000_0000;
      O_MEM_WDATA              <= 32'h0000_0000;
      O_CU_STATE               <= `BDS_CU_IDLE;
      O_NEXT_ADDR              <= 32'h0000_0000;
      O_UNIT_IDLE_EVENT        <= 1'b0;
      O_UNIT_LEFT_ACTIVE_EVENT <= 1'b0;
      O_COMMAND_DONE_EVENT     <= 1'b0;
      O_SELFTEST_FAIL          <= 1'b0;
    end else begin
      test_start               <= 1'b0;
      O_UNIT_IDLE_EVENT        <= 1'b0;
      O_UNIT_LEFT_ACTIVE_EVENT <= 1'b0;
      O_COMMAND_DONE_EVENT     <= 1'b0;
      case (state)
        FS_IDLE: begin
          if ((I_START && O_CU_STATE == `BDS_CU_IDLE) ||
              (I_RESUME && O_CU_STATE == `BDS_CU_SUSPENDED)) begin
            if (I_START) begin
              cb_addr    <= bds_add(I_CU_BASE, I_CB_OFFSET);
              O_MEM_ADDR <= bds_add(I_CU_BASE, I_CB_OFFSET);
            end else begin
              cb_addr    <= O_NEXT_ADDR;
              O_MEM_ADDR <= O_NEXT_ADDR;
            end
            O_CU_STATE <= `BDS_CU_ACTIVE;
            O_MEM_REQ  <= 1'b1;
            O_MEM_WE   <= 1'b0;
            state      <= FS_WORD0;
          end
        end
        FS_WORD0: begin
          if (I_MEM_ACK) begin
            cmd_word   <= I_MEM_RDATA;
            O_MEM_ADDR <= bds_add(cb_addr, `BDS_CB_LINK_OFS);
            state      <= FS_LINK;
          end
        end
        FS_LINK: begin
          if (I_MEM_ACK) begin
            link      <= I_MEM_RDATA;
            O_MEM_REQ <= 1'b0;
            state     <= FS_TEST;
          end
        end
        FS_TEST: begin
          if (bds_is_diag(cmd_word)) begin
            test_start <= 1'b1;
            state      <= FS_WAIT;
          end else begin
            ok_flag   <= 1'b0;
            fail_flag <= 1'b0;
            state     <= FS_STATUS;
          end
        end
        FS_WAIT: begin
          if (test_done) begin
            ok_flag         <= ~test_fail;
            fail_flag       <= test_fail;
            O_SELFTEST_FAIL <= test_fail;
            state           <= FS_STATUS;
          end
        end
        FS_STATUS: begin
          O_MEM_REQ   <= 1'b1;
          O_MEM_WE    <= 1'b1;
          O_MEM_ADDR  <= bds_add(cb_addr, `BDS_CB_WORD0_OFS);
          O_MEM_WDATA <= {cmd_word[31:16], 1'b1, 1'b0, ok_flag, 1'b0, fail_flag, 11'h000};
          state       <= FS_FINISH;
        end
        FS_FINISH: begin
          if (I_MEM_ACK) begin
            O_MEM_REQ            <= 1'b0;
            O_MEM_WE             <= 1'b0;
            O_NEXT_ADDR          <= bds_add(I_CU_BASE, link);
            O_COMMAND_DONE_EVENT <= cmd_word[`BDS_BIT_IRQ];
            if (cmd_word[`BDS_BIT_EOL]) begin
              O_CU_STATE        <= `BDS_CU_IDLE;
              O_UNIT_IDLE_EVENT <= 1'b1;
              state             <= FS_IDLE;
            end else if (cmd_word[`BDS_BIT_SUSPEND]) begin
              O_CU_STATE               <= `BDS_CU_SUSPENDED;
              O_UNIT_LEFT_ACTIVE_EVENT <= I_CFG_SUSPEND_EVENT_EN;
              state                    <= FS_IDLE;
            end else begin
              cb_addr    <= bds_add(I_CU_BASE, link);
              O_MEM_ADDR <= bds_add(I_CU_BASE, link);
              O_MEM_REQ  <= 1'b1;
              state      <= FS_WORD0;
            end
          end
        end
        default: begin
          state <= FS_IDLE;
        end
      endcase
    end
  end

endmodule // bds_top

// ### verif/bds_top_monitor.sv
// Concurrent checks on the diagnose command block ports
`timescale 1ns/1ps
`include "bds_map.vh"

module bds_top_monitor (
  input wire        I_CLK,
  input wire        I_RST_B,
  input wire        I_MEM_ACK,
  input wire        O_MEM_REQ,
  input wire        O_MEM_WE,
  input wire [31:0] O_MEM_ADDR,
  input wire [31:0] O_MEM_WDATA,
  input wire [1:0]  O_CU_STATE,
  input wire        O_UNIT_IDLE_EVENT,
  input wire        O_COMMAND_DONE_EVENT,
  input wire        O_SELFTEST_FAIL
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);

  sequence wr_ack;
    O_MEM_REQ && O_MEM_WE && I_MEM_ACK;
  endsequence
  sequence rd_ack;
    O_MEM_REQ && !O_MEM_WE && I_MEM_ACK;
  endsequence
  sequence wr_seen;
    O_MEM_REQ && O_MEM_WE;
  endsequence

  req_hold_a: assert property (O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_WE)
    && $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA)) else $error("request dropped or changed before ack");
  link_step_a: assert property (rd_ack ##1 (O_MEM_REQ && !O_MEM_WE) |->
    O_MEM_ADDR == $past(O_MEM_ADDR) + 32'h0000_0004) else $error("link word not read at next word");
  status_done_a: assert property (wr_seen |-> O_MEM_WDATA[15]) else $error("completion flag not set");
  pass_fail_a: assert property (wr_seen ##0 O_MEM_WDATA[18:16] == `BDS_CMD_DIAGNOSE |->
    O_MEM_WDATA[11] == O_SELFTEST_FAIL && O_MEM_WDATA[13] == !O_SELFTEST_FAIL) else $error("bad pass fail");
  other_cmd_a: assert property (wr_seen ##0 O_MEM_WDATA[18:16] != `BDS_CMD_DIAGNOSE |->
    !O_MEM_WDATA[13] && !O_MEM_WDATA[11]) else $error("non diagnose status wrong");
  done_evt_a: assert property (wr_ack ##0 O_MEM_WDATA[29] |-> ##[1:2] O_COMMAND_DONE_EVENT)
    else $error("done event missing");
  idle_evt_a: assert property (wr_ack ##0 O_MEM_WDATA[31] |-> ##[1:2] (O_UNIT_IDLE_EVENT
    && O_CU_STATE == `BDS_CU_IDLE)) else $error("idle event missing");
  suspend_state_a: assert property (wr_ack ##0 (O_MEM_WDATA[30] && !O_MEM_WDATA[31]) |->
    ##[1:2] O_CU_STATE == `BDS_CU_SUSPENDED) else $error("not suspended");
  evt_pulse_a: assert property (O_COMMAND_DONE_EVENT |=> !O_COMMAND_DONE_EVENT)
    else $error("done event longer than one cycle");
endmodule // bds_top_monitor

bind bds_top bds_top_monitor u_bds_top_monitor (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_MEM_ACK(I_MEM_ACK),
  .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA),
  .O_CU_STATE(O_CU_STATE), .O_UNIT_IDLE_EVENT(O_UNIT_IDLE_EVENT),
  .O_COMMAND_DONE_EVENT(O_COMMAND_DONE_EVENT), .O_SELFTEST_FAIL(O_SELFTEST_FAIL));

// ### verif/tb.sv
// Self-checking testbench for the diagnose command block
`timescale 1ns/1ps

module tb;
  reg         I_CLK, I_RST_B, I_START, I_RESUME, I_CFG_SUSPEND_EVENT_EN, I_MEM_ACK;
  reg  [31:0] I_CU_BASE, I_CB_OFFSET, I_MEM_RDATA, a, a2, lk;
  wire        O_MEM_REQ, O_MEM_WE, O_UNIT_IDLE_EVENT, O_UNIT_LEFT_ACTIVE_EVENT, O_COMMAND_DONE_EVENT;
  wire        O_SELFTEST_FAIL;
  wire [31:0] O_MEM_ADDR, O_MEM_WDATA, O_NEXT_ADDR;
  wire [1:0]  O_CU_STATE;
  integer     err_total, tests_run, n_idle, n_left, n_done, c;

  bds_top u_bds_top (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_START(I_START), .I_RESUME(I_RESUME),
    .I_CU_BASE(I_CU_BASE), .I_CB_OFFSET(I_CB_OFFSET), .I_CFG_SUSPEND_EVENT_EN(I_CFG_SUSPEND_EVENT_EN),
    .I_MEM_ACK(I_MEM_ACK), .I_MEM_RDATA(I_MEM_RDATA), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WE(O_MEM_WE),
    .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .O_CU_STATE(O_CU_STATE), .O_NEXT_ADDR(O_NEXT_ADDR),
    .O_UNIT_IDLE_EVENT(O_UNIT_IDLE_EVENT), .O_UNIT_LEFT_ACTIVE_EVENT(O_UNIT_LEFT_ACTIVE_EVENT),
    .O_COMMAND_DONE_EVENT(O_COMMAND_DONE_EVENT), .O_SELFTEST_FAIL(O_SELFTEST_FAIL));

  initial begin
    I_CLK = 0;
    forever #5 I_CLK = ~I_CLK;
  end

  // Event pulse counters
  always @(posedge I_CLK) begin
    n_idle <= n_idle + (O_UNIT_IDLE_EVENT === 1'b1);
    n_left <= n_left + (O_UNIT_LEFT_ACTIVE_EVENT === 1'b1);
    n_done <= n_done + (O_COMMAND_DONE_EVENT === 1'b1);
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
        begin
          err_total = err_total + 1;
          $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    end
  endtask

  task tally_and_finish;
    begin
      $display("Compares %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Memory answer: wait for a request, check it, ack after a random delay
  // Back-to-back beat waits at least mw cycles so ack is never lowered and raised in one step
  task serve(input [31:0] d, input integer lim, input we, input [31:0] ad, input [31:0] wd, input integer mw);
    integer k;
    begin
      k = 0;
      while (O_MEM_REQ !== 1'b1 && k < lim) begin
        @(negedge I_CLK);
        k = k + 1;
      end
      check(O_MEM_REQ, 1);
      check(O_MEM_WE, we);
      check(O_MEM_ADDR, ad);
      if (we) check(O_MEM_WDATA, wd);
      repeat (mw + $urandom % 3) @(negedge I_CLK);
      I_MEM_ACK = 1;
      I_MEM_RDATA = d;
      @(negedge I_CLK);
      I_MEM_ACK = 0;
      I_MEM_RDATA = ~d;
    end
  endtask

  // One command block: two reads, status write, events and state
  task blk(input [31:0] w0, input [31:0] lnk, input [31:0] ad);
    integer i0, l0, d0;
    reg dx;
    begin
      dx = (w0[18:16] == 3'h7);
      i0 = n_idle;
      l0 = n_left;
      d0 = n_done;
      serve(w0, 200, 0, ad, 0, 0);
      serve(lnk, 200, 0, ad + 32'h0000_0004, 0, 1);
      serve(0, 60000, 1, ad, {w0[31:16], 2'b10, dx, 13'h0000}, 0);
      repeat (4) @(negedge I_CLK);
      check(n_done - d0, w0[29]);
      check(n_idle - i0, w0[31]);
      if (!w0[31]) check(n_left - l0, w0[30] & I_CFG_SUSPEND_EVENT_EN);
      check(O_NEXT_ADDR, I_CU_BASE + lnk);
      check(O_CU_STATE, w0[31] ? 0 : w0[30] ? 2 : 1);
      if (dx) check(O_SELFTEST_FAIL, 0);
    end
  endtask

  task kick(input r);
    begin
      if (r) I_RESUME = 1;
      else I_START = 1;
      @(negedge I_CLK);
      I_START = 0;
      I_RESUME = 0;
    end
  endtask

  initial begin
    #900000;
    err_total = err_total + 1;
    $display("FAIL %0t watchdog expired", $time);
    tally_and_finish;
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    n_idle = 0;
    n_left = 0;
    n_done = 0;
    {I_RST_B, I_START, I_RESUME, I_MEM_ACK, I_MEM_RDATA} = 0;
    I_CFG_SUSPEND_EVENT_EN = 1;
    void'($urandom(32'h9d8b));
    I_CU_BASE = $urandom & 32'hFFFF_F000;
    I_CB_OFFSET = ($urandom % 64) * 16;
    lk = 32'h0000_0400 + ($urandom % 64) * 16;
    a = I_CU_BASE + I_CB_OFFSET;
    repeat (20) @(negedge I_CLK);
    I_RST_B = 1;
    // Diagnose chain, reserved bits kept zero, ending at end of list
    kick(0);
    blk(32'h2007_0000, lk, a);
    blk(32'h8007_0000, 32'h0000_0040, I_CU_BASE + lk);
    $display("Chain test done");
    // Suspend with event, then resume through every other code
    kick(0);
    blk(32'h6007_0000, lk, a);
    kick(1);
    a2 = I_CU_BASE + lk;
    for (c = 0; c < 7; c = c + 1) begin
      blk({c == 6, 2'b01, 10'h000, c[2:0], 16'h0000}, lk + 32'h0000_0040 * (c + 1), a2);
      a2 = I_CU_BASE + lk + 32'h0000_0040 * (c + 1);
    end
    $display("Suspend test done");
    // Silent suspend, then end of list beating suspend
    I_CFG_SUSPEND_EVENT_EN = 0;
    kick(0);
    blk(32'h4007_0000, lk, a);
    kick(1);
    blk(32'hC007_0000, 32'h0000_0000, I_CU_BASE + lk);
    $display("Silent suspend test done");
    tally_and_finish;
  end
endmodule // tb
